// >>> qdcuc_pkg.sv
package qdcuc_pkg;
	// serial command word layout
	localparam int WORD_W = 24;
	localparam int DATA_W = 16;
	localparam int NCH    = 4;
	localparam int RW_BIT = 23;
	localparam int REG_HI = 21;
	localparam int REG_LO = 19;
	localparam int CH_HI  = 18;
	localparam int CH_LO  = 16;

	// register select codes
	localparam logic [2:0] REG_FUNC   = 3'h0;
	localparam logic [2:0] REG_DATA   = 3'h2;
	localparam logic [2:0] REG_COARSE = 3'h3;
	localparam logic [2:0] REG_FINE   = 3'h4;
	localparam logic [2:0] REG_OFFSET = 3'h5;

	// channel select and function register options
	localparam logic [2:0] CH_ALL   = 3'h4;
	localparam logic [2:0] FN_CTRL  = 3'h1;
	localparam logic [2:0] FN_CLEAR = 3'h4;
	localparam logic [2:0] FN_LOAD  = 3'h5;
	localparam int         FN_W       = 6;
	localparam int         FN_SDO_DIS = 0;

	// codes
	localparam logic [15:0] CLEAR_CODE = 16'h0000;
	localparam logic [15:0] MID_FLIP   = 16'h8000;

	// frame timing
	localparam logic [4:0] LAST_EDGE   = 5'h17;
	localparam logic [4:0] FRAME_EDGES = 5'h18;
	localparam logic [4:0] EDGE_SAT    = 5'h19;
	localparam logic [1:0] SETTLE_CYC  = 2'h2;

	// synchroniser vector
	localparam int         SYNC_W   = 6;
	localparam int         SI_FRAME = 0;
	localparam int         SI_WORD  = 1;
	localparam int         SI_OVF   = 2;
	localparam int         SI_LOAD  = 3;
	localparam int         SI_CLR   = 4;
	localparam int         SI_COD   = 5;
	localparam logic [5:0] SYNC_RST = 6'h19;

	// local register port map
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h1;
	localparam logic [3:0] ADDR_FUNC    = 4'h2;
	localparam logic [1:0] ADDR_CH_PAGE = 2'h1;
	localparam int         CTRL_SW_CLEAR = 0;
	localparam int         CTRL_SW_LOAD  = 1;
	localparam int         CTRL_BAD_CLR  = 2;
	localparam int         ST_CODING = 0;
	localparam int         ST_CLEAR  = 1;
	localparam int         ST_BAD    = 2;
	localparam int         ST_LOAD   = 3;
endpackage

// >>> qdcuc_sync.sv
module qdcuc_sync #(
	parameter int             W   = 1,
	parameter logic [W-1:0]   RST = '0
) (
	// clock and reset
	input  logic         clk,
	input  logic         rst,
	// levels
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} qdcuc_sync_t;

	qdcuc_sync_t s_r;
	qdcuc_sync_t s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '{s1: RST, s2: RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;
endmodule

// >>> qdcuc_link.sv
module qdcuc_link (
	// link clock and reset
	input  logic        serial_clk,
	input  logic        rst,
	// link pins
	input  logic        sync_n,
	input  logic        serial_in,
	output logic        serial_out,
	// from the core, static between frames
	input  logic [23:0] rb_word,
	input  logic        sdo_dis,
	// to the core
	output logic [23:0] word_hold,
	output logic        word_tgl,
	output logic        ovf_tgl
);
	typedef struct packed {
		logic [4:0]  cnt;
		logic [22:0] sh;
	} qdcuc_shift_t;

	typedef struct packed {
		logic [23:0] word;
		logic        word_t;
		logic        ovf_t;
	} qdcuc_hold_t;

	qdcuc_shift_t c_r;
	qdcuc_shift_t c_nxt;
	qdcuc_hold_t  h_r;
	qdcuc_hold_t  h_nxt;
	logic         sdo_r;
	logic         sdo_nxt;

	always_comb begin
		c_nxt     = c_r;
		c_nxt.sh  = {c_r.sh[21:0], serial_in};
		c_nxt.cnt = (c_r.cnt == qdcuc_pkg::EDGE_SAT) ? c_r.cnt : c_r.cnt + 5'h01;
		h_nxt     = h_r;
		if (c_r.cnt == qdcuc_pkg::LAST_EDGE) begin
			h_nxt.word   = {c_r.sh, serial_in};
			h_nxt.word_t = ~h_r.word_t;
		end
		if (c_r.cnt == qdcuc_pkg::FRAME_EDGES) begin
			h_nxt.ovf_t = ~h_r.ovf_t;
		end
		// past the word, the shifted input ripples out for chaining
		if (sdo_dis) begin
			sdo_nxt = 1'b0;
		end else if (c_r.cnt < qdcuc_pkg::FRAME_EDGES) begin
			sdo_nxt = rb_word[qdcuc_pkg::LAST_EDGE - c_r.cnt];
		end else begin
			sdo_nxt = c_r.sh[22];
		end
	end

	// frame sync high empties the counter, so no sclk edge is needed between frames
	always_ff @(negedge serial_clk or posedge rst or posedge sync_n) begin
		if (rst) begin
			c_r <= '0;
		end else if (sync_n) begin
			c_r <= '0;
		end else begin
			c_r <= c_nxt;
		end
	end

	always_ff @(negedge serial_clk or posedge rst) begin
		if (rst) begin
			h_r <= '0;
		end else begin
			h_r <= h_nxt;
		end
	end

	// clock idles low: each rising edge presents the bit sampled at the next fall
	always_ff @(posedge serial_clk or posedge rst) begin
		if (rst) begin
			sdo_r <= 1'b0;
		end else begin
			sdo_r <= sdo_nxt;
		end
	end

	assign serial_out = sdo_r;
	assign word_hold  = h_r.word;
	assign word_tgl   = h_r.word_t;
	assign ovf_tgl    = h_r.ovf_t;

	property p_word_capture;
		@(negedge serial_clk) disable iff (rst || sync_n)
		(c_r.cnt == qdcuc_pkg::LAST_EDGE) |=> (h_r.word == $past({c_r.sh, serial_in})
			&& h_r.word_t != $past(h_r.word_t));
	endproperty
	a_word_capture: assert property (p_word_capture) else $error("word not captured at edge 24");

	property p_overrun;
		@(negedge serial_clk) disable iff (rst || sync_n)
		(c_r.cnt == qdcuc_pkg::FRAME_EDGES) |=> (h_r.ovf_t != $past(h_r.ovf_t)
			&& h_r.word == $past(h_r.word));
	endproperty
	a_overrun: assert property (p_overrun) else $error("edge 25 not flagged");
endmodule

// >>> qdcuc_top.sv
// Operation
// - load strobe falling edge copies all input registers to all outputs.
// - codes read as offset binary or twos complement per coding select.
// - clear input falling edge clears all outputs to the coding's clear level.
// - after clear, outputs hold the cleared value until new data is loaded.
// - clear input low at power-on updates all outputs with the clear value.
// - serial word 0x04xxxx clears all outputs like the clear input.
// - word is MSB first: rw, zero, register select, channel select, 16 data.
// - top bit set means read request, clear means write.
// - register select 000 function, 010 data, 100 fine gain.
// - channel select 000-011 picks one channel, 100 all four.
// - register select 011 addresses the coarse gain register.
// - register select 101 addresses the offset register.
// - exactly 24 falling clock edges per frame; update at frame sync rise.
// - after a read request the next frame shifts out the addressed register.
module qdcuc_top (
	// clock and reset
	input  logic             ref_clk,
	input  logic             rst,
	// register port
	input  logic [3:0]       reg_addr,
	input  logic [15:0]      reg_wdata,
	input  logic             reg_wr,
	input  logic             reg_rd,
	output logic [15:0]      reg_rdata,
	// serial link
	input  logic             serial_clk,
	input  logic             sync_n,
	input  logic             serial_in,
	output logic             serial_out,
	// control pins
	input  logic             load_strobe_n,
	input  logic             async_clear_n,
	input  logic             coding_select,
	// converter codes, signed view
	output logic [3:0][15:0] channel_output
);
	typedef struct packed {
		logic             sync_q;
		logic             load_q;
		logic             clr_q;
		logic [1:0]       settle;
		logic             word_seen;
		logic             ovf_seen;
		logic [3:0][15:0] in_code;
		logic [3:0][15:0] dac_code;
		logic [3:0][15:0] out_code;
		logic [3:0][1:0]  coarse;
		logic [3:0][5:0]  fine;
		logic [3:0][7:0]  offs;
		logic [5:0]       func;
		logic [23:0]      rb_word;
		logic             bad;
		logic [15:0]      rdata;
	} qdcuc_state_t;

	localparam qdcuc_state_t ST_RST = '{sync_q: 1'b1, load_q: 1'b1, clr_q: 1'b1, default: '0};

	qdcuc_state_t s_r;
	qdcuc_state_t n;

	logic [23:0] word_hold;
	logic        word_tgl;
	logic        ovf_tgl;
	logic [5:0]  sy;
	logic        sync_s;
	logic        word_s;
	logic        ovf_s;
	logic        load_s;
	logic        clr_s;
	logic        cod_s;
	logic        sync_rise;
	logic        load_fall;
	logic        clr_fall;
	logic        eval;
	logic        exec;
	logic        rw;
	logic [2:0]  rsel;
	logic [2:0]  csel;
	logic [15:0] data;
	logic [15:0] rb_val;
	logic        sw_clear;
	logic        ld_all;
	logic        bus_clear;
	logic        bus_load;
	logic        direct_wr;
	logic        load_any;
	logic        clear_any;
	logic        dac_touch;

	qdcuc_link u_link (
		.serial_clk (serial_clk),
		.rst        (rst),
		.sync_n     (sync_n),
		.serial_in  (serial_in),
		.serial_out (serial_out),
		.rb_word    (s_r.rb_word),
		.sdo_dis    (s_r.func[qdcuc_pkg::FN_SDO_DIS]),
		.word_hold  (word_hold),
		.word_tgl   (word_tgl),
		.ovf_tgl    (ovf_tgl)
	);

	// clear level resets high, so a clear held low from power-on arrives as an edge
	qdcuc_sync #(
		.W   (qdcuc_pkg::SYNC_W),
		.RST (qdcuc_pkg::SYNC_RST)
	) u_sync (
		.clk (ref_clk),
		.rst (rst),
		.d   ({coding_select, async_clear_n, load_strobe_n, ovf_tgl, word_tgl, sync_n}),
		.q   (sy)
	);

	assign sync_s = sy[qdcuc_pkg::SI_FRAME];
	assign word_s = sy[qdcuc_pkg::SI_WORD];
	assign ovf_s  = sy[qdcuc_pkg::SI_OVF];
	assign load_s = sy[qdcuc_pkg::SI_LOAD];
	assign clr_s  = sy[qdcuc_pkg::SI_CLR];
	assign cod_s  = sy[qdcuc_pkg::SI_COD];

	always_comb begin
		n         = s_r;
		n.rdata   = '0;
		rb_val    = '0;
		sw_clear  = 1'b0;
		ld_all    = 1'b0;
		direct_wr = 1'b0;
		sync_rise = sync_s & ~s_r.sync_q;
		load_fall = s_r.load_q & ~load_s;
		clr_fall  = s_r.clr_q & ~clr_s;
		n.sync_q  = sync_s;
		n.load_q  = load_s;
		n.clr_q   = clr_s;
		// toggles and frame sync share synchroniser depth; wait out their skew
		eval = (s_r.settle == 2'h1);
		exec = eval && (word_s != s_r.word_seen) && (ovf_s == s_r.ovf_seen);
		rw   = word_hold[qdcuc_pkg::RW_BIT];
		rsel = word_hold[qdcuc_pkg::REG_HI:qdcuc_pkg::REG_LO];
		csel = word_hold[qdcuc_pkg::CH_HI:qdcuc_pkg::CH_LO];
		data = word_hold[qdcuc_pkg::DATA_W-1:0];
		if (sync_rise) begin
			n.settle = qdcuc_pkg::SETTLE_CYC;
		end else if (s_r.settle != 2'h0) begin
			n.settle = s_r.settle - 2'h1;
		end
		bus_clear = reg_wr && (reg_addr == qdcuc_pkg::ADDR_CTRL)
			&& reg_wdata[qdcuc_pkg::CTRL_SW_CLEAR];
		bus_load  = reg_wr && (reg_addr == qdcuc_pkg::ADDR_CTRL)
			&& reg_wdata[qdcuc_pkg::CTRL_SW_LOAD];
		if (reg_wr && (reg_addr == qdcuc_pkg::ADDR_CTRL) && reg_wdata[qdcuc_pkg::CTRL_BAD_CLR]) begin
			n.bad = 1'b0;
		end
		// a short or long frame is dropped and leaves a sticky flag; set beats clear
		if (eval) begin
			n.word_seen = word_s;
			n.ovf_seen  = ovf_s;
			if (!exec) begin
				n.bad = 1'b1;
			end
		end
		if (exec && !rw) begin
			case (rsel)
				qdcuc_pkg::REG_FUNC: begin
					case (csel)
						qdcuc_pkg::FN_CTRL: n.func = data[qdcuc_pkg::FN_W-1:0];
						qdcuc_pkg::FN_CLEAR: sw_clear = 1'b1;
						qdcuc_pkg::FN_LOAD: ld_all = 1'b1;
						default: ;
					endcase
				end
				qdcuc_pkg::REG_DATA: begin
					for (int k = 0; k < qdcuc_pkg::NCH; k++) begin
						if (csel == qdcuc_pkg::CH_ALL || csel == 3'(k)) begin
							n.in_code[k] = data;
							// load strobe sampled at frame end; host holds it steady per word
							if (!load_s) begin
								n.dac_code[k] = data;
								direct_wr     = 1'b1;
							end
						end
					end
				end
				qdcuc_pkg::REG_COARSE: begin
					for (int k = 0; k < qdcuc_pkg::NCH; k++) begin
						if (csel == qdcuc_pkg::CH_ALL || csel == 3'(k)) begin
							n.coarse[k] = data[1:0];
						end
					end
				end
				qdcuc_pkg::REG_FINE: begin
					for (int k = 0; k < qdcuc_pkg::NCH; k++) begin
						if (csel == qdcuc_pkg::CH_ALL || csel == 3'(k)) begin
							n.fine[k] = data[5:0];
						end
					end
				end
				qdcuc_pkg::REG_OFFSET: begin
					for (int k = 0; k < qdcuc_pkg::NCH; k++) begin
						if (csel == qdcuc_pkg::CH_ALL || csel == 3'(k)) begin
							n.offs[k] = data[7:0];
						end
					end
				end
				default: ;
			endcase
		end
		// readback value is snapshotted now; later writes do not show in it
		if (exec && rw) begin
			case (rsel)
				qdcuc_pkg::REG_FUNC: rb_val = {10'h000, s_r.func};
				qdcuc_pkg::REG_DATA: rb_val = s_r.in_code[csel[1:0]];
				qdcuc_pkg::REG_COARSE: rb_val = {14'h0000, s_r.coarse[csel[1:0]]};
				qdcuc_pkg::REG_FINE: rb_val = {10'h000, s_r.fine[csel[1:0]]};
				qdcuc_pkg::REG_OFFSET: rb_val = {8'h00, s_r.offs[csel[1:0]]};
				default: rb_val = '0;
			endcase
			n.rb_word = {word_hold[qdcuc_pkg::WORD_W-1:qdcuc_pkg::DATA_W], rb_val};
		end
		load_any  = load_fall | ld_all | bus_load;
		clear_any = clr_fall | sw_clear | bus_clear;
		dac_touch = load_any | clear_any | direct_wr;
		if (load_any) begin
			n.dac_code = n.in_code;
		end
		// clear wins over any load in the same cycle
		if (clear_any) begin
			for (int k = 0; k < qdcuc_pkg::NCH; k++) begin
				n.in_code[k]  = qdcuc_pkg::CLEAR_CODE;
				n.dac_code[k] = qdcuc_pkg::CLEAR_CODE;
			end
		end
		for (int k = 0; k < qdcuc_pkg::NCH; k++) begin
			n.out_code[k] = cod_s ? (s_r.dac_code[k] ^ qdcuc_pkg::MID_FLIP) : s_r.dac_code[k];
		end
		if (reg_rd) begin
			if (reg_addr[3:2] == qdcuc_pkg::ADDR_CH_PAGE) begin
				n.rdata = s_r.dac_code[reg_addr[1:0]];
			end else if (reg_addr == qdcuc_pkg::ADDR_STATUS) begin
				n.rdata[qdcuc_pkg::ST_CODING] = cod_s;
				n.rdata[qdcuc_pkg::ST_CLEAR]  = clr_s;
				n.rdata[qdcuc_pkg::ST_BAD]    = s_r.bad;
				n.rdata[qdcuc_pkg::ST_LOAD]   = load_s;
			end else if (reg_addr == qdcuc_pkg::ADDR_FUNC) begin
				n.rdata = {10'h000, s_r.func};
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= ST_RST;
		end else begin
			s_r <= n;
		end
	end

	assign reg_rdata      = s_r.rdata;
	assign channel_output = s_r.out_code;

	property p_load_all;
		@(posedge ref_clk) disable iff (rst)
		(load_fall && !clear_any && !exec) |=> (s_r.dac_code == $past(s_r.in_code));
	endproperty
	a_load_all: assert property (p_load_all) else $error("load edge did not update outputs");

	property p_coding;
		@(posedge ref_clk) disable iff (rst)
		##1 (s_r.out_code[2] == ($past(cod_s) ? ($past(s_r.dac_code[2]) ^ 16'h8000)
			: $past(s_r.dac_code[2])));
	endproperty
	a_coding: assert property (p_coding) else $error("output coding mismatch");

	property p_clear_pin;
		@(posedge ref_clk) disable iff (rst)
		clr_fall |=> (s_r.dac_code == '0 && s_r.in_code == '0) ##1 (cod_s || s_r.out_code == '0);
	endproperty
	a_clear_pin: assert property (p_clear_pin) else $error("clear edge did not clear");

	property p_hold;
		@(posedge ref_clk) disable iff (rst)
		!dac_touch |=> $stable(s_r.dac_code);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved without load");

	property p_poweron;
		@(posedge ref_clk) disable iff (rst)
		$fell(clr_s) |=> (s_r.dac_code == '0);
	endproperty
	a_poweron: assert property (p_poweron) else $error("low clear level not applied");

	property p_sw_clear;
		@(posedge ref_clk) disable iff (rst)
		(exec && word_hold[23:16] == 8'h04) |=> (s_r.dac_code == '0);
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("software clear failed");

	property p_read_no_write;
		@(posedge ref_clk) disable iff (rst)
		(exec && rw && !clear_any) |=> $stable(s_r.in_code) && $stable(s_r.func);
	endproperty
	a_read_no_write: assert property (p_read_no_write) else $error("read changed a register");

	property p_fine;
		@(posedge ref_clk) disable iff (rst)
		(exec && !rw && rsel == 3'h4 && csel == 3'h3) |=> (s_r.fine[3] == $past(data[5:0]));
	endproperty
	a_fine: assert property (p_fine) else $error("fine gain not stored");

	property p_chan;
		@(posedge ref_clk) disable iff (rst)
		(exec && !rw && rsel == 3'h2 && csel == 3'h1 && !clear_any)
		|=> (s_r.in_code[1] == $past(data) && s_r.in_code[0] == $past(s_r.in_code[0]));
	endproperty
	a_chan: assert property (p_chan) else $error("channel decode wrong");

	property p_coarse;
		@(posedge ref_clk) disable iff (rst)
		(exec && !rw && rsel == 3'h3 && csel == 3'h2) |=> (s_r.coarse[2] == $past(data[1:0]));
	endproperty
	a_coarse: assert property (p_coarse) else $error("coarse gain not stored");

	property p_offset;
		@(posedge ref_clk) disable iff (rst)
		(exec && !rw && rsel == 3'h5 && csel == 3'h0) |=> (s_r.offs[0] == $past(data[7:0]));
	endproperty
	a_offset: assert property (p_offset) else $error("offset not stored");

	property p_bad_frame;
		@(posedge ref_clk) disable iff (rst)
		(sync_rise ##2 (ovf_s != s_r.ovf_seen && !clear_any))
		|=> (s_r.bad && $stable(s_r.in_code));
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("bad frame accepted");

	property p_readback;
		@(posedge ref_clk) disable iff (rst)
		(exec && rw && rsel == 3'h2 && csel == 3'h0) |=> (s_r.rb_word[15:0] == $past(s_r.in_code[0]));
	endproperty
	a_readback: assert property (p_readback) else $error("readback word wrong");

	property p_direct;
		@(posedge ref_clk) disable iff (rst)
		(exec && !rw && rsel == 3'h2 && csel == 3'h3 && !load_s && !clear_any)
		|=> (s_r.dac_code[3] == $past(data));
	endproperty
	a_direct: assert property (p_direct) else $error("direct update missed");

	property p_all;
		@(posedge ref_clk) disable iff (rst)
		(exec && !rw && rsel == 3'h2 && csel == 3'h4 && !clear_any)
		|=> (s_r.in_code == {4{$past(data)}});
	endproperty
	a_all: assert property (p_all) else $error("all-channel write failed");
endmodule

// >>> qdcuc_host_model.sv
module qdcuc_host_model (
	// link pins driven by the host
	output logic serial_clk,
	output logic sync_n,
	output logic serial_in,
	// readback from the device
	input  logic serial_out
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam time HALF = 24ns;

	// clock rests low between frames, as a gated burst source would leave it
	initial begin
		serial_clk = 1'b0;
		sync_n     = 1'b1;
		serial_in  = 1'b0;
	end

	// edges other than 24 are only sent when a frame is meant to be dropped
	task automatic xfer(input logic [23:0] word, input int edges, output logic [23:0] rx);
		rx = 24'h000000;
		#7;
		sync_n = 1'b0;
		for (int i = 0; i < edges; i++) begin
			// data moves on the rise, well clear of the sampling fall
			#HALF serial_clk = 1'b1;
			serial_in = (i < 24) ? word[23 - i] : 1'b0;
			#HALF rx = {rx[22:0], serial_out};
			serial_clk = 1'b0;
		end
		#HALF sync_n = 1'b1;
		// released line flips so a stale bit is never mistaken for data
		serial_in = ~serial_in;
	endtask
endmodule

// >>> tb.sv
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic             ref_clk = 1'b0;
	logic             rst;
	logic [3:0]       reg_addr;
	logic [15:0]      reg_wdata;
	logic             reg_wr;
	logic             reg_rd;
	logic [15:0]      reg_rdata;
	logic             serial_clk;
	logic             sync_n;
	logic             serial_in;
	logic             serial_out;
	logic             load_strobe_n;
	logic             async_clear_n;
	logic             coding_select;
	logic [3:0][15:0] chan_out;
	logic [23:0]      rx;
	int               error_cnt = 0;
	int               n_compared = 0;
	int               cyc = 0;

	always #12.5 ref_clk = ~ref_clk;

	qdcuc_top u_dut (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.serial_clk     (serial_clk),
		.sync_n         (sync_n),
		.serial_in      (serial_in),
		.serial_out     (serial_out),
		.load_strobe_n  (load_strobe_n),
		.async_clear_n  (async_clear_n),
		.coding_select  (coding_select),
		.channel_output (chan_out)
	);

	qdcuc_host_model u_host (
		.serial_clk (serial_clk),
		.sync_n     (sync_n),
		.serial_in  (serial_in),
		.serial_out (serial_out)
	);

	task automatic report_and_stop();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// generous: a frame is about 50 core cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	// one frame, then enough idle time for the core to act on it
	task automatic frame(input logic [2:0] rg, input logic [2:0] ch, input logic [15:0] d,
			input logic rd = 1'b0, input int edges = 24);
		u_host.xfer({rd, 1'b0, rg, ch, d}, edges, rx);
		settle(12);
	endtask

	task automatic chk_all(input logic [15:0] e);
		for (int k = 0; k < 4; k++) begin
			`CHK(chan_out[k], e)
		end
	endtask

	task automatic pins(input logic ld, input logic clr, input logic cod);
		@(posedge ref_clk);
		load_strobe_n <= ld;
		async_clear_n <= clr;
		coding_select <= cod;
		settle(8);
	endtask

	logic [2:0]  rb_reg [4] = '{qdcuc_pkg::REG_COARSE, qdcuc_pkg::REG_FINE,
		qdcuc_pkg::REG_OFFSET, qdcuc_pkg::REG_DATA};
	logic [2:0]  rb_ch  [4] = '{3'h2, 3'h0, 3'h3, 3'h1};
	logic [15:0] rb_val [4] = '{16'h0002, 16'h0015, 16'h0055, 16'h7fff};

	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		load_strobe_n = 1'b1;
		async_clear_n = 1'b0;
		coding_select = 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		// clear held low through power-on, binary coding: negative full scale
		pins(1'b1, 1'b1, 1'b1);
		chk_all(16'h8000);
		reg_chk(qdcuc_pkg::ADDR_STATUS, 16'h000b);
		reg_chk(4'h3, 16'h0000);
		reg_chk(qdcuc_pkg::ADDR_CTRL, 16'h0000);
		pins(1'b1, 1'b1, 1'b0);
		chk_all(16'h0000);
		// individual update with the strobe held low
		pins(1'b0, 1'b1, 1'b0);
		for (int k = 0; k < 4; k++) begin
			frame(qdcuc_pkg::REG_DATA, 3'(k), 16'h1000 + 16'(k));
			`CHK(chan_out[k], 16'h1000 + 16'(k))
			reg_chk(4'h4 + 4'(k), 16'h1000 + 16'(k));
		end
		// simultaneous update: strobe high while shifting, falls later
		pins(1'b1, 1'b1, 1'b0);
		frame(qdcuc_pkg::REG_DATA, qdcuc_pkg::CH_ALL, 16'h7fff);
		`CHK(chan_out[3], 16'h1003)
		pins(1'b0, 1'b1, 1'b0);
		chk_all(16'h7fff);
		pins(1'b1, 1'b1, 1'b0);
		frame(qdcuc_pkg::REG_DATA, 3'h2, 16'h8000);
		`CHK(chan_out[2], 16'h7fff)
		frame(qdcuc_pkg::REG_FUNC, qdcuc_pkg::FN_LOAD, 16'h0000);
		`CHK(chan_out[2], 16'h8000)
		// short and long frames are dropped even with the strobe low
		pins(1'b0, 1'b1, 1'b0);
		for (int n = 23; n <= 25; n += 2) begin
			frame(qdcuc_pkg::REG_DATA, 3'h0, 16'h0abc, 1'b0, n);
			`CHK(chan_out[0], 16'h7fff)
			reg_chk(qdcuc_pkg::ADDR_STATUS, 16'h0006);
			reg_write(qdcuc_pkg::ADDR_CTRL, 16'h0004);
		end
		pins(1'b1, 1'b1, 1'b0);
		reg_chk(qdcuc_pkg::ADDR_STATUS, 16'h000a);
		frame(qdcuc_pkg::REG_COARSE, 3'h2, 16'h0002);
		frame(qdcuc_pkg::REG_FINE, 3'h0, 16'h0015);
		frame(qdcuc_pkg::REG_OFFSET, 3'h3, 16'h0055);
		// read request carries junk data that must not be written
		for (int k = 0; k < 4; k++) begin
			frame(rb_reg[k], rb_ch[k], 16'hffff, 1'b1);
			frame(qdcuc_pkg::REG_FUNC, 3'h0, 16'h0000);
			`CHK(rx, {2'b10, rb_reg[k], rb_ch[k], rb_val[k]})
		end
		// load over the port: junk data of the read requests must not surface
		reg_write(qdcuc_pkg::ADDR_CTRL, 16'h0002);
		settle(2);
		`CHK(chan_out[1], 16'h7fff)
		// readback pin disabled through the function register shifts zeros
		frame(qdcuc_pkg::REG_FUNC, qdcuc_pkg::FN_CTRL, 16'h0001);
		reg_chk(qdcuc_pkg::ADDR_FUNC, 16'h0001);
		frame(qdcuc_pkg::REG_FUNC, 3'h0, 16'h0000);
		`CHK(rx, 24'h000000)
		frame(qdcuc_pkg::REG_FUNC, qdcuc_pkg::FN_CTRL, 16'h0000);
		reg_chk(qdcuc_pkg::ADDR_FUNC, 16'h0000);
		frame(qdcuc_pkg::REG_FUNC, qdcuc_pkg::FN_CLEAR, 16'hbeef);
		chk_all(16'h0000);
		frame(qdcuc_pkg::REG_DATA, qdcuc_pkg::CH_ALL, 16'h1234);
		pins(1'b0, 1'b1, 1'b0);
		chk_all(16'h1234);
		pins(1'b1, 1'b1, 1'b0);
		// clear held low well past its minimum
		pins(1'b1, 1'b0, 1'b0);
		pins(1'b1, 1'b1, 1'b0);
		chk_all(16'h0000);
		pins(1'b0, 1'b1, 1'b0);
		chk_all(16'h0000);
		reg_chk(4'h4, 16'h0000);
		pins(1'b1, 1'b1, 1'b1);
		chk_all(16'h8000);
		// port load then port clear, seen in offset binary
		frame(qdcuc_pkg::REG_DATA, qdcuc_pkg::CH_ALL, 16'h4321);
		reg_write(qdcuc_pkg::ADDR_CTRL, 16'h0002);
		settle(2);
		chk_all(16'hc321);
		reg_write(qdcuc_pkg::ADDR_CTRL, 16'h0001);
		settle(2);
		chk_all(16'h8000);
		report_and_stop();
	end
endmodule
